// ==== inc/asrc_pkg.sv ====
// constants and types shared by the converter readout control
package asrc_pkg;

  localparam int CAL_CLOCKS  = 14000;   // conversion-clock cycles
  localparam int ACQ_CLOCKS  = 4;       // acquisition periods
  localparam int RESULT_BITS = 16;
  localparam int SYNC_STAGES = 2;

  // idle falling edges counted before a start may take place
  localparam logic [1:0] ACQ_WAIT = 2'(ACQ_CLOCKS - 1);

  // range/shutdown select pin levels
  localparam logic [1:0] RSS_SHUTDOWN = 2'h0;
  localparam logic [1:0] RSS_UNIPOLAR = 2'h1;
  localparam logic [1:0] RSS_BIPOLAR  = 2'h2;

  // values after reset
  localparam logic RST_EOC_N = 1'h1;
  localparam logic RST_DOUT  = 1'h0;

  typedef enum logic [2:0] {
    ST_CAL  = 3'h1,
    ST_IDLE = 3'h2,
    ST_CONVERT_REQUEST_N = 3'h4
  } asrc_state_e;

endpackage

// ==== verilog/asrc_link_edge.sv ====
// serial-clock side: one toggle per falling edge of the serial clock
`timescale 1ns/100ps
module asrc_link_edge
  import asrc_pkg::*;
(
  input  wire logic sclk,
  input  wire logic reset_n,
  output logic      link_toggle
);

  typedef struct packed {
    logic tgl;
  } asrc_link_s;

  asrc_link_s st_q;
  asrc_link_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // the serial clock stands still outside bursts, so reset cannot wait
  // for its edges: this single flop is cleared without it
  always_comb
  begin
    st_d     = st_q;
    st_d.tgl = ~st_q.tgl;
  end

  always_ff @(negedge sclk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign link_toggle = st_q.tgl;

endmodule

// ==== verilog/asrc_core.sv ====
// calibration, conversion sequencing and serial readout of the converter
`timescale 1ns/100ps

module asrc_core
  import asrc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CLOCKS,
  parameter int WIDTH      = RESULT_BITS
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       convert_request_n_clk,
  input  wire logic       serial_clk,
  input  wire logic       convert_request_n,
  input  wire logic [1:0] range_shutdown_select,
  input  wire logic       burst_mode,
  input  wire logic       comparator_bit,
  output logic            serial_data_out,
  output logic            end_of_convert_request_n_n,
  output logic            bipolar_range,
  output logic            shutdown_active
);

  localparam int CW = $clog2(CAL_CYCLES);
  localparam int BW = $clog2(WIDTH);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WIDTH - 1);

  typedef struct packed {
    asrc_state_e      fsm;
    logic [CW-1:0]    cal_cnt;
    logic [1:0]       idle_cnt;
    logic [BW-1:0]    bit_cnt;
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] shift;
    logic             dout;
    logic             eoc_n;
    logic             shdn;
    logic             bipolar;
    logic [2:0]       cclk;
    logic [1:0]       req;
    logic [1:0]       cmp;
    logic [1:0]       mode;
    logic [1:0]       rss1;
    logic [1:0]       rss2;
    logic [2:0]       lt;
  } asrc_core_s;

  asrc_core_s       st_q;
  asrc_core_s       st_d;
  logic             link_toggle;
  logic             convert_request_n_fall;
  logic             link_evt;
  logic [WIDTH-1:0] next_result;

  ////////////////////////////////////////////////////////////////////////////
  asrc_link_edge u_link (
    .sclk        (serial_clk),
    .reset_n     (reset_n),
    .link_toggle (link_toggle)
  );

  // edges are taken past the synchronisers; a stage is read only by the next
  assign convert_request_n_fall   = st_q.cclk[2] & ~st_q.cclk[1];
  assign link_evt    = st_q.lt[2] ^ st_q.lt[1];
  assign next_result = {st_q.result[WIDTH-2:0], st_q.cmp[1]};

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d         = st_q;
    st_d.cclk    = {st_q.cclk[1:0], convert_request_n_clk};
    st_d.req     = {st_q.req[0], convert_request_n};
    st_d.cmp     = {st_q.cmp[0], comparator_bit};
    st_d.mode    = {st_q.mode[0], burst_mode};
    st_d.rss1    = range_shutdown_select;
    st_d.rss2    = st_q.rss1;
    st_d.lt      = {st_q.lt[1:0], link_toggle};
    st_d.shdn    = (st_q.rss2 == RSS_SHUTDOWN);
    st_d.bipolar = (st_q.rss2 == RSS_BIPOLAR);
    // burst read between conversions; a tied-low serial clock never steps it
    if (link_evt && st_q.mode[1] && st_q.fsm == ST_IDLE)
    begin
      st_d.shift = {st_q.shift[WIDTH-2:0], 1'b0};
      st_d.dout  = st_q.shift[WIDTH-2];
    end
    // shutdown holds calibration and conversion (burst reads still step), so calibration data survive it
    if (convert_request_n_fall && !st_q.shdn)
    begin
      unique case (st_q.fsm)
        ST_CAL:
        begin
          if (st_q.cal_cnt == CAL_LAST)
          begin
            st_d.fsm      = ST_IDLE;
            st_d.eoc_n    = 1'b0;
            st_d.idle_cnt = 2'h0;
          end
          else
            st_d.cal_cnt = st_q.cal_cnt + 1'b1;
        end
        ST_IDLE:
        begin
          // counting from the last end keeps four acquisition periods
          if (!st_q.req[1] && st_q.idle_cnt == ACQ_WAIT)
          begin
            st_d.fsm     = ST_CONVERT_REQUEST_N;
            st_d.eoc_n   = 1'b1;
            st_d.bit_cnt = '0;
            st_d.result  = '0;
          end
          else if (st_q.idle_cnt != ACQ_WAIT)
            st_d.idle_cnt = st_q.idle_cnt + 2'h1;
        end
        ST_CONVERT_REQUEST_N:
        begin
          st_d.result = next_result;
          if (!st_q.mode[1])
            st_d.dout = st_q.cmp[1];
          if (st_q.bit_cnt == LAST_BIT)
          begin
            st_d.fsm      = ST_IDLE;
            st_d.eoc_n    = 1'b0;
            st_d.idle_cnt = 2'h0;
            st_d.shift    = next_result;
            if (st_q.mode[1])
              st_d.dout = next_result[WIDTH-1];
          end
          else
            st_d.bit_cnt = st_q.bit_cnt + 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st_q       <= '0;
      st_q.fsm   <= ST_CAL;
      st_q.eoc_n <= RST_EOC_N;
      st_q.dout  <= RST_DOUT;
    end
    else
      st_q <= st_d;
  end

  assign serial_data_out = st_q.dout;
  assign end_of_convert_request_n_n   = st_q.eoc_n;
  assign bipolar_range   = st_q.bipolar;
  assign shutdown_active = st_q.shdn;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_cal_done_eoc:
    assert property ((st_q.fsm == ST_CAL && convert_request_n_fall && !st_q.shdn &&
                      st_q.cal_cnt == CAL_LAST) |=>
                     (st_q.fsm == ST_IDLE && !end_of_convert_request_n_n))
    else $error("end of calibration not flagged");

  a_cal_eoc_high:
    assert property (st_q.fsm == ST_CAL |-> end_of_convert_request_n_n)
    else $error("end-of-conversion low during calibration");

  a_start_edge:
    assert property ((st_q.fsm == ST_IDLE && convert_request_n_fall && !st_q.shdn &&
                      !st_q.req[1] && st_q.idle_cnt == ACQ_WAIT) |=>
                     (st_q.fsm == ST_CONVERT_REQUEST_N && end_of_convert_request_n_n))
    else $error("conversion did not start on the due edge");

  a_acq_time:
    assert property ($rose(st_q.fsm == ST_CONVERT_REQUEST_N) |->
                     $past(st_q.idle_cnt) == ACQ_WAIT)
    else $error("conversion began before acquisition time");

  a_bit_present:
    assert property ((st_q.fsm == ST_CONVERT_REQUEST_N && convert_request_n_fall && !st_q.shdn &&
                      !st_q.mode[1]) |=>
                     serial_data_out == $past(st_q.cmp[1]))
    else $error("decided bit not presented");

  a_dout_on_fall:
    assert property ((!st_q.mode[1] && !convert_request_n_fall) |=>
                     $stable(serial_data_out))
    else $error("mode 1 output moved off a clock fall");

  a_word_length:
    assert property ((st_q.fsm == ST_CONVERT_REQUEST_N && convert_request_n_fall && !st_q.shdn &&
                      st_q.bit_cnt == LAST_BIT) |=>
                     (st_q.fsm == ST_IDLE && !end_of_convert_request_n_n))
    else $error("conversion length wrong");

  a_burst_msb:
    assert property ((st_q.fsm == ST_CONVERT_REQUEST_N && convert_request_n_fall && !st_q.shdn &&
                      st_q.bit_cnt == LAST_BIT && st_q.mode[1]) |=>
                     serial_data_out == st_q.result[WIDTH-1])
    else $error("burst does not open with the top bit");

  a_burst_shift:
    assert property ((st_q.fsm == ST_IDLE && link_evt && st_q.mode[1] &&
                      !convert_request_n_fall) |=>
                     serial_data_out == $past(st_q.shift[WIDTH-2]))
    else $error("serial clock fall did not advance the output");

  a_sclk_unused:
    assert property ((!st_q.mode[1] && st_q.fsm != ST_CONVERT_REQUEST_N) |=>
                     $stable(st_q.shift))
    else $error("serial clock acted in mode 1");

  a_shdn_hold:
    assert property (st_q.shdn |=>
                     ($stable(st_q.fsm) && $stable(st_q.cal_cnt) &&
                      $stable(st_q.bit_cnt)))
    else $error("state moved during shutdown");

endmodule

// ==== bench/asrc_host_model.sv ====
// host model: conversion clock, serial clock and decision bits
`timescale 1ns/100ps
module asrc_host_model
(
  input  wire logic ref_clk,
  output logic      convert_request_n_clk,
  output logic      serial_clk,
  output logic      comparator_bit
);
  initial
  begin
    convert_request_n_clk       = 1'b1;
    serial_clk     = 1'b0;  // stands low outside bursts
    comparator_bit = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // clean full periods only; short pulses would upset the device
  task automatic convert_request_n_fall(input logic b);
    comparator_bit = b;
    repeat (4) @(negedge ref_clk);
    convert_request_n_clk = 1'b0;
    repeat (8) @(negedge ref_clk);
    convert_request_n_clk = 1'b1;
  endtask
  // one 6 ns serial pulse, then a gap long enough for the output
  task automatic sclk_pulse;
    @(negedge ref_clk);
    #3;
    serial_clk = 1'b1;
    #6;
    serial_clk = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// ==== bench/asrc_core_bench.sv ====
// self-checking bench for the converter readout control
`timescale 1ns/100ps
module asrc_core_bench;
  import asrc_pkg::*;
  localparam int          CALN = 20;
  localparam logic [15:0] W1   = 16'hB5C3;
  localparam logic [15:0] W2   = 16'h4A3C;
  logic       ref_clk, reset_n, convert_request_n_clk, serial_clk, req_n, mode;
  logic       cmp, dout, eoc_n, bip, shd;
  logic [1:0] sel;
  int         err_total, total_checks;
  asrc_host_model i_host (.ref_clk(ref_clk), .convert_request_n_clk(convert_request_n_clk),
    .serial_clk(serial_clk), .comparator_bit(cmp));
  asrc_core #(.CAL_CYCLES(CALN)) i_dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .convert_request_n_clk(convert_request_n_clk), .serial_clk(serial_clk),
    .convert_request_n(req_n), .range_shutdown_select(sel),
    .burst_mode(mode), .comparator_bit(cmp), .serial_data_out(dout),
    .end_of_convert_request_n_n(eoc_n), .bipolar_range(bip), .shutdown_active(shd));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // the request level is changed only on a falling ref edge
  task automatic request(input logic lvl);
    req_n = lvl;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_cal;
    repeat (CALN - 1) i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b1, "cal ended early");
    i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b0, "cal not ended");
  endtask
  // request held from the end: start only on the fourth fall
  task automatic t_mode1;
    request(1'b0);
    repeat (3) i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b0, "started before acquisition");
    i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b1, "no start on fourth fall");
    request(1'b1);
    for (int k = 15; k >= 0; k--)
    begin
      i_host.convert_request_n_fall(W1[k]);
      chk(dout, W1[k], "mode 1 bit");
      chk(eoc_n, k != 0, "mode 1 end");
    end
  endtask
  // late request starts on the next fall; burst read after the end
  task automatic t_mode2;
    mode = 1'b1;
    repeat (5) i_host.convert_request_n_fall(1'b0);
    request(1'b0);
    i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b1, "late start missed");
    request(1'b1);
    for (int k = 15; k >= 0; k--)
      i_host.convert_request_n_fall(W2[k]);
    chk(eoc_n, 1'b0, "mode 2 end");
    chk(dout, W2[15], "mode 2 first bit");
    for (int k = 14; k >= 0; k--)
    begin
      i_host.sclk_pulse();
      chk(dout, W2[k], "mode 2 bit");
    end
    // next conversion after the burst; no falls since the end, so 4th fall
    request(1'b0);
    repeat (3) i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b0, "restart before acquisition");
    i_host.convert_request_n_fall(1'b0);
    request(1'b1);
    chk(eoc_n, 1'b1, "no restart after burst");
    i_host.convert_request_n_fall(1'b1);
    repeat (15) i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b0, "restart did not end");
    chk(dout, 1'b1, "restart top bit");
  endtask
  // falls in shutdown are ignored even with a request pending
  task automatic t_shdn;
    sel = RSS_SHUTDOWN;
    repeat (4) @(negedge ref_clk);
    chk(shd, 1'b1, "no shutdown");
    request(1'b0);
    repeat (6) i_host.convert_request_n_fall(1'b0);
    chk(eoc_n, 1'b0, "converted in shutdown");
    request(1'b1);
    sel = RSS_BIPOLAR;
    repeat (4) @(negedge ref_clk);
    chk(bip, 1'b1, "no bipolar");
    chk(shd, 1'b0, "still shut down");
  endtask
  // mid-run reset: outputs fall back and calibration runs again
  task automatic t_rerst;
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(eoc_n, RST_EOC_N, "reset eoc mid-run");
    chk(dout, RST_DOUT, "reset dout mid-run");
    chk(bip, 1'b0, "reset range");
    reset_n = 1'b1;
    t_cal();
  endtask
  // every select code; code 3 reads as unipolar
  task automatic t_select;
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      repeat (4) @(negedge ref_clk);
      chk(shd, s == 0, "select shutdown");
      chk(bip, s == 2, "select range");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    total_checks = 0;
    reset_n = 1'b0;
    request(1'b1);
    mode = 1'b0;
    sel = RSS_UNIPOLAR;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    chk(eoc_n, RST_EOC_N, "reset eoc");
    t_cal();
    t_mode1();
    t_mode2();
    t_shdn();
    t_rerst();
    t_select();
    final_report();
  end
  // whole run needs about 40 us; allow ample margin
  initial
  begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
